// ===== core/ldc_ctrl_regs.sv
`timescale 1ns/10ps
`include "ldc_cfg.svh"

module ldc_ctrl_regs (
   input  wire logic             CLK_SYS,      // System clock, 250 MHz
   input  wire logic             RST_N,        // Async reset, active low
   input  wire ldc_pkg::ldc_req_s REQ,         // Host byte access
   output logic [7:0]            RDATA,        // Read data, registered
   output logic                  ACK,          // Byte accepted, combinational
   input  wire logic [5:0]       CONV_RESULT,  // Converter result bits
   input  wire logic             VOL_MODE,     // Volatility mode bit
   input  wire logic             GEN1_DIR,     // Generator one direction bit
   input  wire logic             GEN2_DIR,     // Generator two direction bit
   output logic                  NV_WR,        // Nonvolatile store pulse
   output logic [7:0]            NV_ADDR,      // Nonvolatile store address
   output logic [7:0]            NV_DATA,      // Nonvolatile store data
   output ldc_pkg::ldc_gen_s     GEN1,         // Generator one settings
   output ldc_pkg::ldc_gen_s     GEN2          // Generator two settings
);
   import ldc_pkg::*;

   // Storage registers
   logic [5:0] row1_q, row1_d;   // Table-one row bits
   logic [5:0] row2_q, row2_d;   // Table-two row bits
   logic [7:0] val1_q, val1_d;   // Converter-one value bits
   logic [7:0] val2_q, val2_d;   // Converter-two value bits
   logic [7:0] src_q, src_d;     // Source select and ranges
   logic       wel_q, wel_d;     // Write-enable latch
   logic [7:0] rdata_d;          // Read data next
   logic       nv_wr_d;          // Store pulse next
   logic [7:0] nv_addr_d;        // Store address next
   logic [7:0] nv_data_d;        // Store data next
   logic       wr_ok;            // Write permitted
   ldc_gen_s   gen1_d, gen2_d;   // Generator settings next

   // Table address: base plus six-bit row
   function automatic logic [7:0] table_addr(input logic [7:0] base, input logic [5:0] row);
      table_addr = base + {2'h0, row};
   endfunction

   // Range decode shared by both generators
   function automatic logic range_ext(input logic [1:0] code);
      range_ext = (code == LDC_RANGE_EXT);
   endfunction

   // Latch register writes are always allowed; others need the latch
   assign wr_ok = REQ.wr && (wel_q || REQ.addr == `LDC_ADDR_WEN);
   assign ACK   = REQ.rd || wr_ok;

   // Next-state for register file
   always_comb begin
      row1_d    = row1_q;
      row2_d    = row2_q;
      val1_d    = val1_q;
      val2_d    = val2_q;
      src_d     = src_q;
      wel_d     = wel_q;
      nv_wr_d   = 1'b0;
      nv_addr_d = NV_ADDR;
      nv_data_d = NV_DATA;
      if (wr_ok) begin
         unique case (REQ.addr)
            `LDC_ADDR_ROW1: row1_d = REQ.wdata[5:0];
            `LDC_ADDR_ROW2: row2_d = REQ.wdata[5:0];
            `LDC_ADDR_VAL1: val1_d = REQ.wdata;
            `LDC_ADDR_VAL2: val2_d = REQ.wdata;
            `LDC_ADDR_SRC:  src_d  = REQ.wdata;
            `LDC_ADDR_WEN: begin
               // Only the two command values touch the latch
               if (REQ.wdata == `LDC_WEL_SET) begin
                  wel_d = 1'b1;
               end else if (REQ.wdata == `LDC_WEL_CLR) begin
                  wel_d = 1'b0;
               end
            end
            default: ;  // Reserved and status bytes ignore writes
         endcase
         // Nonvolatile copy
         if (REQ.addr == `LDC_ADDR_SRC) begin
            nv_wr_d   = 1'b1;
            nv_addr_d = REQ.addr;
            nv_data_d = REQ.wdata;
         end else if (VOL_MODE && REQ.addr >= `LDC_ADDR_ROW1 && REQ.addr <= `LDC_ADDR_VAL2) begin
            nv_wr_d   = 1'b1;
            nv_addr_d = REQ.addr;
            nv_data_d = REQ.wdata;
         end
      end
   end

   // Read mux
   always_comb begin
      rdata_d = RDATA;
      if (REQ.rd) begin
         unique case (REQ.addr)
            `LDC_ADDR_ROW1:   rdata_d = {2'h0, row1_q};
            `LDC_ADDR_ROW2:   rdata_d = {2'h0, row2_q};
            `LDC_ADDR_VAL1:   rdata_d = val1_q;
            `LDC_ADDR_VAL2:   rdata_d = val2_q;
            `LDC_ADDR_SRC:    rdata_d = src_q;
            `LDC_ADDR_WEN:    rdata_d = {wel_q, 7'h00};
            `LDC_ADDR_RESULT: rdata_d = {CONV_RESULT, 2'h0};
            default:          rdata_d = 8'h00;
         endcase
      end
   end

   // Generator settings decode
   always_comb begin
      gen1_d = '0;
      gen2_d = '0;
      // Table row source, tables one and two
      gen1_d.table_addr = table_addr(`LDC_TABLE1_BASE,
                                     src_q[`LDC_BIT_TABLE1_DS] ? row1_q : CONV_RESULT);
      gen2_d.table_addr = table_addr(`LDC_TABLE2_BASE,
                                     src_q[`LDC_BIT_TABLE2_DS] ? row2_q : CONV_RESULT);
      // Converter input source
      gen1_d.use_table = !src_q[`LDC_BIT_CONV1_DS];
      gen1_d.conv_byte = src_q[`LDC_BIT_CONV1_DS] ? val1_q : 8'h00;
      gen2_d.use_table = !src_q[`LDC_BIT_CONV2_DS];
      gen2_d.conv_byte = src_q[`LDC_BIT_CONV2_DS] ? val2_q : 8'h00;
      // Polarity
      gen1_d.sink = GEN1_DIR;
      gen2_d.sink = GEN2_DIR;
      // Full-scale ranges
      gen1_d.range   = ldc_range_e'(src_q[1:0]);
      gen1_d.ext_res = range_ext(src_q[1:0]);
      gen2_d.range   = ldc_range_e'(src_q[3:2]);
      gen2_d.ext_res = range_ext(src_q[3:2]);
   end

   // Register stage
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         row1_q  <= 6'h00;
         row2_q  <= 6'h00;
         val1_q  <= `LDC_RST_BYTE;
         val2_q  <= `LDC_RST_BYTE;
         src_q   <= `LDC_RST_SRC;
         wel_q   <= 1'b0;
         RDATA   <= 8'h00;
         NV_WR   <= 1'b0;
         NV_ADDR <= 8'h00;
         NV_DATA <= 8'h00;
         GEN1    <= '0;
         GEN2    <= '0;
      end else begin
         row1_q  <= row1_d;
         row2_q  <= row2_d;
         val1_q  <= val1_d;
         val2_q  <= val2_d;
         src_q   <= src_d;
         wel_q   <= wel_d;
         RDATA   <= rdata_d;
         NV_WR   <= nv_wr_d;
         NV_ADDR <= nv_addr_d;
         NV_DATA <= nv_data_d;
         GEN1    <= gen1_d;
         GEN2    <= gen2_d;
      end
   end

   // Assertions
   sequence s_wel_set;
      REQ.wr && REQ.addr == `LDC_ADDR_WEN && REQ.wdata == `LDC_WEL_SET;
   endsequence

   sequence s_locked_write;
      REQ.wr && !wel_q && REQ.addr != `LDC_ADDR_WEN;
   endsequence

   a_wel_set_latch: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      s_wel_set |=> wel_q) else $error("Latch not set");

   a_locked_noack: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      s_locked_write ##0 !REQ.rd |-> !ACK) else $error("Unenabled write acknowledged");

   a_locked_hold: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      s_locked_write |=> $stable(src_q) && $stable(val1_q)) else $error("Unenabled write changed register");

   a_table1_conv: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      !src_q[`LDC_BIT_TABLE1_DS] |=> GEN1.table_addr == `LDC_TABLE1_BASE + {2'h0, $past(CONV_RESULT)})
      else $error("Table one not following converter");

   a_table1_row: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      src_q[`LDC_BIT_TABLE1_DS] |=> GEN1.table_addr == `LDC_TABLE1_BASE + {2'h0, $past(row1_q)})
      else $error("Table one row wrong");

   a_table2_addr: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      1'b1 |=> GEN2.table_addr >= `LDC_TABLE2_BASE) else $error("Table two address out of range");

   a_conv2_direct: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      src_q[`LDC_BIT_CONV2_DS] |=> GEN2.conv_byte == $past(val2_q) && !GEN2.use_table)
      else $error("Converter two not direct");

   a_nv_mode: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      wr_ok && !VOL_MODE && REQ.addr == `LDC_ADDR_VAL1 |=> !NV_WR) else $error("Volatile write stored");

   a_status_read: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      REQ.rd && REQ.addr == `LDC_ADDR_RESULT |=> RDATA == {$past(CONV_RESULT), 2'h0})
      else $error("Status read wrong");

   a_reserved_zero: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      REQ.rd && REQ.addr >= `LDC_ADDR_RSV_LO && REQ.addr <= `LDC_ADDR_RSV_HI |=> RDATA == 8'h00)
      else $error("Reserved byte not zero");

   // Latch clear command seen on the bus
   sequence s_wel_clear;
      REQ.wr && REQ.addr == `LDC_ADDR_WEN && REQ.wdata == `LDC_WEL_CLR;
   endsequence

   // Write with the latch already open
   sequence s_open_write;
      REQ.wr && wel_q;
   endsequence

   // Permitted write to the source-select byte
   sequence s_src_write;
      REQ.wr && wel_q && REQ.addr == `LDC_ADDR_SRC;
   endsequence

   // Latch command, latch read and enabled-write acknowledge checks
   a_wel_clear_latch: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      s_wel_clear |=> !wel_q)
      else $error("Latch not cleared");

   a_wel_other_hold: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      REQ.wr && REQ.addr == `LDC_ADDR_WEN && REQ.wdata != `LDC_WEL_SET && REQ.wdata != `LDC_WEL_CLR |=> $stable(wel_q))
      else $error("Latch moved by other value");

   a_open_ack: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      s_open_write |-> ACK)
      else $error("Enabled write not acknowledged");

   a_wen_read: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      REQ.rd && REQ.addr == `LDC_ADDR_WEN |=> RDATA == {$past(wel_q), 7'h00})
      else $error("Latch read wrong");

   // Register file write checks and row read padding check
   a_src_store: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      s_src_write |=> src_q == $past(REQ.wdata) && NV_WR)
      else $error("Source select not stored");

   a_row1_write: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      s_open_write ##0 REQ.addr == `LDC_ADDR_ROW1 |=> row1_q == $past(REQ.wdata[5:0]))
      else $error("Row one not written");

   a_val1_write: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      s_open_write ##0 REQ.addr == `LDC_ADDR_VAL1 |=> val1_q == $past(REQ.wdata))
      else $error("Value one not written");

   a_read_row_pad: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      REQ.rd && REQ.addr == `LDC_ADDR_ROW1 |=> RDATA[7:6] == 2'h0)
      else $error("Row reserved bits not zero");

   // Nonvolatile copy checks
   a_nv_copy: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      s_open_write ##0 (VOL_MODE && REQ.addr == `LDC_ADDR_VAL2)
      |=> NV_WR && NV_ADDR == `LDC_ADDR_VAL2 && NV_DATA == $past(REQ.wdata))
      else $error("Nonvolatile copy missing");

   a_nv_idle: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      !wr_ok |=> !NV_WR)
      else $error("Store pulse without write");

   // Generator setting checks
   a_table2_conv: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      !src_q[`LDC_BIT_TABLE2_DS] |=> GEN2.table_addr == `LDC_TABLE2_BASE + {2'h0, $past(CONV_RESULT)})
      else $error("Table two not following converter");

   a_table2_row: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      src_q[`LDC_BIT_TABLE2_DS] |=> GEN2.table_addr == `LDC_TABLE2_BASE + {2'h0, $past(row2_q)})
      else $error("Table two row wrong");

   a_conv1_direct: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      src_q[`LDC_BIT_CONV1_DS] |=> GEN1.conv_byte == $past(val1_q) && !GEN1.use_table)
      else $error("Converter one not direct");

   a_conv1_table: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      !src_q[`LDC_BIT_CONV1_DS] |=> GEN1.use_table)
      else $error("Converter one not from table");

   a_gen2_sink: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      1'b1 |=> GEN2.sink == $past(GEN2_DIR))
      else $error("Generator two direction wrong");

   a_gen1_range: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      1'b1 |=> GEN1.range == ldc_range_e'($past(src_q[1:0])) && GEN1.ext_res == ($past(src_q[1:0]) == 2'h0))
      else $error("Generator one range wrong");

   a_gen2_range: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      1'b1 |=> GEN2.range == ldc_range_e'($past(src_q[3:2])) && GEN2.ext_res == ($past(src_q[3:2]) == 2'h0))
      else $error("Generator two range wrong");

endmodule // ldc_ctrl_regs

// ===== core/ldc_cfg.svh
`ifndef LDC_CFG_SVH
`define LDC_CFG_SVH
// Register byte addresses
`define LDC_ADDR_ROW1      8'h81
`define LDC_ADDR_ROW2      8'h82
`define LDC_ADDR_VAL1      8'h83
`define LDC_ADDR_VAL2      8'h84
`define LDC_ADDR_SRC       8'h85
`define LDC_ADDR_WEN       8'h86
`define LDC_ADDR_RESULT    8'h87
`define LDC_ADDR_RSV_LO    8'h88
`define LDC_ADDR_RSV_HI    8'h8F
// Table base byte addresses
`define LDC_TABLE1_BASE    8'h90
`define LDC_TABLE2_BASE    8'hD0
// Source-select field positions
`define LDC_BIT_CONV2_DS   7
`define LDC_BIT_TABLE2_DS  6
`define LDC_BIT_CONV1_DS   5
`define LDC_BIT_TABLE1_DS  4
// Write-enable latch position and command values
`define LDC_BIT_WEL        7
`define LDC_WEL_SET        8'h80
`define LDC_WEL_CLR        8'h00
// Reset values
`define LDC_RST_SRC        8'h00
`define LDC_RST_BYTE       8'h00
`endif

// ===== core/ldc_pkg.sv
package ldc_pkg;
   // Full-scale range selection codes
   typedef enum logic [1:0] {
      LDC_RANGE_EXT  = 2'h0,
      LDC_RANGE_LOW  = 2'h1,
      LDC_RANGE_MID  = 2'h2,
      LDC_RANGE_HIGH = 2'h3
   } ldc_range_e;

   // Host byte access request
   typedef struct packed {
      logic       wr;     // Write strobe
      logic       rd;     // Read strobe
      logic [7:0] addr;   // Byte address
      logic [7:0] wdata;  // Write data
   } ldc_req_s;

   // Settings driving one current generator
   typedef struct packed {
      logic [7:0] table_addr;  // Selected table byte address
      logic [7:0] conv_byte;   // Byte fed to the converter
      logic       use_table;   // Converter fed from table row
      logic       sink;        // 1 sink, 0 source
      ldc_range_e range;       // Full-scale range
      logic       ext_res;     // External resistor selected
   } ldc_gen_s;
endpackage

// ===== test/ldc_host_model.sv
`timescale 1ns/10ps
module ldc_host_model (
   input  wire logic         CLK_SYS,  // System clock
   output ldc_pkg::ldc_req_s REQ,      // Byte request to device
   input  wire logic [7:0]   RDATA,    // Read data
   input  wire logic         ACK       // Byte accepted
);
   import ldc_pkg::*;
   // Bus idle until the first access
   initial REQ = '0;
   // One write byte, ACK taken before the taking edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ack);
      REQ = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      #2 ack = ACK;
      @(posedge CLK_SYS) #1;
   endtask
   // One read byte, registered data taken after the edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      REQ = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: ~a};
      @(posedge CLK_SYS) #1 d = RDATA;
   endtask
   // Release; stale address and data are inverted, not kept
   task automatic idle();
      REQ = '{wr: 1'b0, rd: 1'b0, addr: ~REQ.addr, wdata: ~REQ.wdata};
      @(posedge CLK_SYS) #1;
   endtask
endmodule // ldc_host_model

// ===== test/tb.sv
`timescale 1ns/10ps
`include "ldc_cfg.svh"
module tb;
   import ldc_pkg::*;
   logic       clk_sys, rst_n, ack, vol_mode, gen1_dir, gen2_dir, nv_wr, a; // Bench signals
   logic [7:0] rdata, nv_addr, nv_data, d; // Byte signals
   logic [5:0] conv;                       // Converter result
   ldc_req_s   req;                        // Host request
   ldc_gen_s   gen1, gen2;                 // Generator settings
   int         errors = 0;                 // Mismatch count
   int         checked = 0;                // Comparison count
   logic [3:0] sel_tab [4] = '{4'h5, 4'hA, 4'hF, 4'h0}; // Select patterns
   logic [7:0] src;                        // Source-select byte

   ldc_host_model ldc_host_model_i (.CLK_SYS(clk_sys), .REQ(req), .RDATA(rdata), .ACK(ack));
   ldc_ctrl_regs ldc_ctrl_regs_i (.CLK_SYS(clk_sys), .RST_N(rst_n), .REQ(req), .RDATA(rdata),
      .ACK(ack), .CONV_RESULT(conv), .VOL_MODE(vol_mode), .GEN1_DIR(gen1_dir),
      .GEN2_DIR(gen2_dir), .NV_WR(nv_wr), .NV_ADDR(nv_addr), .NV_DATA(nv_data),
      .GEN1(gen1), .GEN2(gen2));

   // Clock, 4 ns period
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
      end
   endtask

   // Read a byte and compare
   task automatic rchk(input logic [7:0] ad, input logic [7:0] exp);
      ldc_host_model_i.rd(ad, d);
      chk(32'(d), 32'(exp));
   endtask

   // Expected generator settings
   function automatic ldc_gen_s exp_gen(input logic ts, input logic cs, input logic dir,
      input logic [5:0] row, input logic [7:0] base, input logic [7:0] val, input logic [1:0] rng);
      exp_gen.table_addr = base + {2'h0, ts ? row : conv};
      exp_gen.conv_byte  = cs ? val : 8'h00;
      exp_gen.use_table  = ~cs;
      exp_gen.sink       = dir;
      exp_gen.range      = ldc_range_e'(rng);
      exp_gen.ext_res    = (rng == 2'h0);
   endfunction

   // Verdict and end of run
   task automatic tally_and_finish();
      if (errors == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Watchdog against a hang
   initial begin
      #20000;
      errors++;
      tally_and_finish();
   end

   // Main sequence
   initial begin
      rst_n = 1'b0;
      conv = 6'h2A;
      vol_mode = 1'b0;
      gen1_dir = 1'b0;
      gen2_dir = 1'b0;
      repeat (5) @(posedge clk_sys);
      #1 rst_n = 1'b1;
      @(posedge clk_sys) #1;
      for (int i = 8'h81; i <= 8'h8F; i++) begin
         rchk(8'(i), (i == 8'h87) ? 8'hA8 : 8'h00);
      end
      chk(32'(gen1), 32'(exp_gen(1'b0, 1'b0, 1'b0, 6'h3F, `LDC_TABLE1_BASE, 8'h00, 2'h0)));
      chk(32'(gen2), 32'(exp_gen(1'b0, 1'b0, 1'b0, 6'h3F, `LDC_TABLE2_BASE, 8'h00, 2'h0)));
      ldc_host_model_i.wr(`LDC_ADDR_SRC, 8'h55, a);
      chk(32'(a), 32'h0);
      rchk(`LDC_ADDR_SRC, 8'h00);
      ldc_host_model_i.wr(`LDC_ADDR_WEN, `LDC_WEL_SET, a);
      chk(32'(a), 32'h1);
      rchk(`LDC_ADDR_WEN, 8'h80);
      ldc_host_model_i.wr(`LDC_ADDR_WEN, 8'hC0, a);
      rchk(`LDC_ADDR_WEN, 8'h80);
      ldc_host_model_i.wr(8'h81, 8'hFF, a);
      ldc_host_model_i.wr(8'h82, 8'hC5, a);
      vol_mode = 1'b1;
      ldc_host_model_i.wr(8'h83, 8'hA5, a);
      chk(32'({nv_wr, nv_addr, nv_data}), {15'h0, 1'b1, 8'h83, 8'hA5});
      vol_mode = 1'b0;
      ldc_host_model_i.wr(8'h84, 8'h5A, a);
      chk(32'(nv_wr), 32'h0);
      rchk(8'h81, 8'h3F);
      rchk(8'h82, 8'h05);
      rchk(8'h83, 8'hA5);
      rchk(8'h84, 8'h5A);
      for (int k = 0; k < 4; k++) begin
         src = {sel_tab[k], ~2'(k), 2'(k)};
         gen1_dir = k[0];
         gen2_dir = k[1];
         ldc_host_model_i.wr(`LDC_ADDR_SRC, src, a);
         chk(32'(nv_wr), 32'h1);
         ldc_host_model_i.idle();
         chk(32'(gen1), 32'(exp_gen(src[4], src[5], k[0], 6'h3F, 8'h90, 8'hA5, 2'(k))));
         chk(32'(gen2), 32'(exp_gen(src[6], src[7], k[1], 6'h05, 8'hD0, 8'h5A, ~2'(k))));
         rchk(`LDC_ADDR_SRC, src);
      end
      ldc_host_model_i.wr(`LDC_ADDR_RESULT, 8'hFF, a);
      ldc_host_model_i.wr(8'h8A, 8'h11, a);
      conv = 6'h15;
      rchk(`LDC_ADDR_RESULT, 8'h54);
      rchk(8'h8A, 8'h00);
      chk(32'(gen1.table_addr), 32'hA5);
      ldc_host_model_i.wr(`LDC_ADDR_WEN, `LDC_WEL_CLR, a);
      rchk(`LDC_ADDR_WEN, 8'h00);
      ldc_host_model_i.wr(8'h83, 8'h00, a);
      chk(32'(a), 32'h0);
      rchk(8'h83, 8'hA5);
      ldc_host_model_i.idle();
      tally_and_finish();
   end
endmodule // tb
